/* ccbg_params.svh */
`ifndef CCBG_PARAMS_SVH
`define CCBG_PARAMS_SVH
`define CCBG_CLK_PERIOD_PS 4000
`define CCBG_HOLD_OFF_NS 125
`define CCBG_HOLD_OFF_CYCLES 1
`define CCBG_COUNT_WIDTH 3
`define CCBG_COUNT_INIT 3'h7
`define CCBG_COUNT_LSB 0
`define CCBG_COUNT_MID 1
`define CCBG_COUNT_MSB 2
`define CCBG_LINE_WIDTH 2
`endif

/* ccbg_pkg.sv */
package ccbg_pkg;
   typedef enum logic [1:0] {
      ccbg_addr_phase,
      ccbg_read_phase,
      ccbg_write_phase
   } ccbg_dir_type;
endpackage : ccbg_pkg

/* ccbg_count.sv */
`timescale 1ns/1ps
`include "ccbg_params.svh"
module ccbg_count #(
   parameter int WIDTH = `CCBG_COUNT_WIDTH
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Control.
   input wire logic load,
   input wire logic [WIDTH-1:0] init_value,
   input wire logic advance,
   input wire logic mid_enable,
   // Count.
   output logic [WIDTH-1:0] count
);
   // The toggle terms below name each bit by position, so only a three bit counter is served.
   if (WIDTH != 3) begin : g_bad_width
      $error("ccbg_count needs exactly three bits");
   end

   // Each bit toggles when all lower bits are zero, bits one and two only while mid_enable is high, making a down counter.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `CCBG_COUNT_INIT;
      end else if (load) begin
         count <= init_value;
      end else if (advance) begin
         count[0] <= ~count[0];
         if (!count[0] && mid_enable) begin
            count[1] <= ~count[1];
         end
         if (!count[0] && !count[1] && mid_enable) begin
            count[2] <= ~count[2];
         end
      end
   end
endmodule : ccbg_count

/* ccbg_glue.sv */
`timescale 1ns/1ps
`include "ccbg_params.svh"
module ccbg_glue #(
   parameter int LINES = `CCBG_LINE_WIDTH,
   parameter bit FAST_READY = 1'b0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Processor bus control.
   input wire logic address_latch_enable,
   input wire logic chip_select,
   input wire logic io_read_command,
   input wire logic io_write_command,
   input wire logic cpu_phase_two,
   input wire logic control_register,
   input wire logic [LINES-1:0] register_address,
   // Processor data lines.
   input wire logic cpu_data_low_in,
   input wire logic cpu_data_high_in,
   output logic cpu_data_low,
   output logic cpu_data_high,
   output logic cpu_data_oe,
   // Cipher chip muxed lines.
   input wire logic muxed_line_low_in,
   input wire logic muxed_line_high_in,
   output logic muxed_line_low,
   output logic muxed_line_high,
   output logic muxed_line_oe,
   // Cipher chip control and timing.
   output logic master_port_select,
   output logic cipher_clock,
   output logic command_hold_off,
   output logic sync_ready_out,
   output logic latched_select
);
   import ccbg_pkg::*;

   // The line mapping below names bit zero and bit one directly, so only two lines can be served.
   if (LINES != 2) begin : g_bad_lines
      $error("ccbg_glue serves exactly two muxed lines");
   end

   // The strobe hold off is one system clock long; the cipher chip only needs a gap after the
   // address latch enable falls, and a longer pulse would stretch every access for nothing.
   localparam int HOLD_OFF_CYCLES = `CCBG_HOLD_OFF_CYCLES;

   // The hold off counter below must be able to hold the pulse length less one.
   if (HOLD_OFF_CYCLES < 1 || HOLD_OFF_CYCLES > 256) begin : g_bad_hold
      $error("ccbg_glue needs a hold off of one to 256 clocks");
   end

   // A transfer may only steer the lines once the address phase is over and the select is latched.
   function automatic logic transfer_ok(input logic selected, input logic latch_enable, input logic strobe);
      return selected && strobe && !latch_enable;
   endfunction : transfer_ok

   // Counter and direction state; the ready bit is chosen before it is qualified by the select.
   logic start;
   logic [`CCBG_COUNT_WIDTH-1:0] count;
   logic [7:0] hold_left;
   ccbg_dir_type next_dir;
   logic read_is_control;
   logic ready_bit;

   // An access to this chip starts wherever the decoder and the address latch enable coincide.
   assign start = address_latch_enable && chip_select;

   // The strobes qualify on the latched select so a decoder glitch mid cycle cannot flip direction.
   always_comb begin
      next_dir = ccbg_addr_phase;
      if (transfer_ok(latched_select, address_latch_enable, io_read_command)) begin
         next_dir = ccbg_read_phase;
      end else if (transfer_ok(latched_select, address_latch_enable, io_write_command)) begin
         next_dir = ccbg_write_phase;
      end
   end

   // The select is only sampled during the address phase, so it stands for the whole access and
   // for the idle time up to the next address phase.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_select <= 1'b0;
      end else if (address_latch_enable) begin
         latched_select <= chip_select;
      end
   end

   // A new pulse needs the previous one to have ended, so an address phase held over two clocks
   // cannot stretch the hold off.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_left <= 8'h00;
         command_hold_off <= 1'b0;
      end else if (start && hold_left == 8'h00 && !command_hold_off) begin
         hold_left <= 8'(HOLD_OFF_CYCLES - 1);
         command_hold_off <= 1'b1;
      end else if (hold_left != 8'h00) begin
         hold_left <= hold_left - 8'h01;
      end else begin
         command_hold_off <= 1'b0;
      end
   end

   // Muxed lines default to address so the cipher chip sees address hold.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         muxed_line_low <= 1'b0;
         muxed_line_high <= 1'b0;
         muxed_line_oe <= 1'b0;
         cpu_data_low <= 1'b0;
         cpu_data_high <= 1'b0;
         cpu_data_oe <= 1'b0;
      end else begin
         case (next_dir)
            ccbg_read_phase: begin
               muxed_line_oe <= 1'b0;
               cpu_data_low <= muxed_line_low_in;
               cpu_data_high <= muxed_line_high_in;
               cpu_data_oe <= 1'b1;
            end
            ccbg_write_phase: begin
               muxed_line_low <= cpu_data_low_in;
               muxed_line_high <= cpu_data_high_in;
               muxed_line_oe <= 1'b1;
               cpu_data_oe <= 1'b0;
            end
            default: begin
               if (address_latch_enable) begin
                  muxed_line_low <= register_address[0];
                  muxed_line_high <= register_address[1];
               end
               muxed_line_oe <= 1'b1;
               cpu_data_oe <= 1'b0;
            end
         endcase
      end
   end

   // The counter is reloaded at every start, which is what keeps the cipher clock in step with
   // the strobes of the access that follows.
   ccbg_count #(
      .WIDTH(`CCBG_COUNT_WIDTH)
   ) counter (
      .clk(clk),
      .rst_n(rst_n),
      .load(start),
      .init_value(`CCBG_COUNT_INIT),
      .advance(1'b1),
      .mid_enable(cpu_phase_two),
      .count(count)
   );

   // The register kind is taken with the select, because the address bits may move once the
   // address latch enable has fallen.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         read_is_control <= 1'b0;
      end else if (start) begin
         read_is_control <= control_register;
      end
   end

   // The cipher clock leaves from a flip-flop one clock behind the middle counter bit; the
   // strobes are timed against this registered copy, so the lag is part of the phase plan.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cipher_clock <= 1'b0;
      end else begin
         cipher_clock <= count[`CCBG_COUNT_MID];
      end
   end

   // The port select follows the decoder, not the latched copy, so it drops as soon as the
   // processor moves on to another device.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         master_port_select <= 1'b0;
      end else begin
         master_port_select <= chip_select;
      end
   end

   // The faster ready is only safe where the cipher chip answers in one wait state.
   always_comb begin
      ready_bit = count[`CCBG_COUNT_MSB];
      if (FAST_READY && !(read_is_control && io_read_command)) begin
         ready_bit = count[`CCBG_COUNT_MID];
      end
   end

   // Ready is qualified by the latched select, so an unselected cycle never answers for this chip.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_ready_out <= 1'b0;
      end else begin
         sync_ready_out <= latched_select && !ready_bit;
      end
   end
endmodule : ccbg_glue

/* ccbg_glue_monitor.sv */
`timescale 1ns/1ps
module ccbg_glue_monitor (
   // Clock, reset and watched ports.
   input logic clk,
   input logic rst_n,
   input logic address_latch_enable,
   input logic chip_select,
   input logic io_read_command,
   input logic io_write_command,
   input logic cpu_data_oe,
   input logic muxed_line_oe,
   input logic master_port_select,
   input logic command_hold_off,
   input logic sync_ready_out,
   input logic latched_select
);
   wire ale = address_latch_enable, ls = latched_select, hold = command_hold_off;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_hold; ale && chip_select && !hold |=> hold ##1 !hold; endproperty
   a_hold: assert property (p_hold) else $error("bad hold off");
   property p_latch; ale |=> ls == $past(chip_select); endproperty
   a_latch: assert property (p_latch) else $error("bad latch");
   property p_addr; ale |=> muxed_line_oe && !cpu_data_oe; endproperty
   a_addr: assert property (p_addr) else $error("bad address phase");
   property p_rd; !ale && ls && io_read_command |=> cpu_data_oe && !muxed_line_oe; endproperty
   a_rd: assert property (p_rd) else $error("bad read path");
   property p_wr; !ale && ls && io_write_command |=> muxed_line_oe && !cpu_data_oe; endproperty
   a_wr: assert property (p_wr) else $error("bad write path");
   property p_idle; !(ls && (io_read_command || io_write_command)) |=> muxed_line_oe; endproperty
   a_idle: assert property (p_idle) else $error("bad address hold");
   property p_mps; 1'b1 |=> master_port_select == $past(chip_select); endproperty
   a_mps: assert property (p_mps) else $error("bad port select");
   property p_off; !ls && !$past(ls) |-> !cpu_data_oe && !hold && !sync_ready_out; endproperty
   a_off: assert property (p_off) else $error("bad idle outputs");
endmodule : ccbg_glue_monitor
bind ccbg_glue ccbg_glue_monitor i_ccbg_glue_monitor (.clk, .rst_n, .address_latch_enable, .chip_select,
   .io_read_command, .io_write_command, .cpu_data_oe, .muxed_line_oe, .master_port_select, .command_hold_off,
   .sync_ready_out, .latched_select);

/* ccbg_cipher_model.sv */
`timescale 1ns/1ps
module ccbg_cipher_model (
   // Strobes and the glue side of the shared lines.
   input logic ale,
   input logic rd,
   input logic oe,
   input logic [1:0] drive,
   output logic [1:0] level
);
   logic [1:0] reg_addr = 2'h0;
   always @(negedge ale) reg_addr <= level;
   // Released lines show the inverse of the address latched at the fall of ale during a read, and of the last drive otherwise.
   always_comb level = oe ? drive : rd ? ~reg_addr : ~drive;
endmodule : ccbg_cipher_model

/* ccbg_glue_tb.sv */
`timescale 1ns/1ps
module ccbg_glue_tb;
   logic clk = 1'b0, rst_n = 1'b0, ale = 1'b0, cs = 1'b0, rd = 1'b0, wr = 1'b0, ph2 = 1'b0, doe, moe, mps, hold, rdy, ls;
   logic [1:0] ra = 2'h0, din = 2'h0, mi, mo, dout;
   logic cclk;
   int bad_count = 0, samples_checked = 0;
   ccbg_glue i_ccbg_glue (.clk(clk), .rst_n(rst_n), .address_latch_enable(ale), .chip_select(cs),
      .io_read_command(rd), .io_write_command(wr), .cpu_phase_two(ph2), .control_register(1'b0),
      .register_address(ra), .cpu_data_low_in(din[0]), .cpu_data_high_in(din[1]), .cpu_data_low(dout[0]),
      .cpu_data_high(dout[1]), .cpu_data_oe(doe), .muxed_line_low_in(mi[0]), .muxed_line_high_in(mi[1]),
      .muxed_line_low(mo[0]), .muxed_line_high(mo[1]), .muxed_line_oe(moe), .master_port_select(mps),
      .cipher_clock(cclk), .command_hold_off(hold), .sync_ready_out(rdy), .latched_select(ls));
   ccbg_cipher_model i_ccbg_cipher_model (.ale(ale), .rd(rd), .oe(moe), .drive(mo), .level(mi));
   always #2 clk = ~clk;
   always @(posedge clk) ph2 <= ~ph2;
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   task automatic chk(string n, logic [3:0] e, logic [3:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // The strobe is held three clocks before the checks, then until ready, so the read data has crossed both register stages.
   task automatic cyc(logic s, logic [1:0] a, logic r, logic w, logic [1:0] d);
      // The address phase must meet a phase two edge, as on the real processor bus.
      if (!ph2) step;
      {ale, cs, ra} = {1'b1, s, a};
      step;
      ale = 1'b0;
      chk("hold", s, hold);
      chk("addr", {1'b1, a}, {moe, mo});
      {rd, wr, din} = {r, w, d};
      repeat (3) step;
      chk("hold_end", 1'b0, hold);
      chk("latched", s, ls);
      chk("data_oe", s & r, doe);
      if (s) chk("cipher_clk", 1'b0, cclk);
      if (s & r) chk("rd_data", {2'h0, ~a}, dout);
      if (s & w) chk("wr_data", {1'b1, d}, {moe, mo});
      repeat (16) if (rdy !== s) step;
      chk("ready", s, rdy);
      if (rdy !== s) test_done;
      {rd, wr} = 2'h0;
      step;
      chk("addr_hold", 1, moe);
   endtask : cyc
   task automatic sc_access;
      for (int a = 0; a < 4; a++) begin
         cyc(1'b1, 2'(a), 1'b1, 1'b0, 2'h0);
         cyc(1'b1, 2'(a), 1'b0, 1'b1, 2'(~a));
         cyc(1'b0, 2'(a), 1'b1, 1'b0, 2'h0);
      end
   endtask : sc_access
   initial begin
      repeat (12) step;
      rst_n = 1'b1;
      sc_access;
      test_done;
   end
endmodule : ccbg_glue_tb
